// [logic/crf_access_if.sv]
// Interface carrying decoded register file accesses.
`timescale 1ns/100ps
interface crf_access_if;
   logic       wrCtrl;
   logic       wrMem;
   logic       rdMem;
   logic [5:0] index;
   logic       bankSel;
   logic [3:0] wrData;
   logic [3:0] memRdData;
   modport ctrl (output wrCtrl, wrMem, rdMem, index, bankSel, wrData,
                 input memRdData);
   modport mem  (input wrMem, rdMem, index, bankSel, wrData,
                 output memRdData);
endinterface : crf_access_if

// [logic/crf_control_regs.sv]
// Control register file with window register transfers.
// ------------------------------------------------------------------
// Summary of operation
// - Control space holds 64 nibbles at addresses 00H to 3FH.
// - Only 26 control nibbles exist and software avoids the other 38.
// - Each implemented nibble is read/write or read-only, one address.
// - Watchdog restart bit 3 and enable bit 0 of 03H accept writes, read 0.
// - Timer restart bit 2 of 11H, 12H and 13H are writable, read 0.
// - Converter start bit 0 of 20H triggers on write and reads 0.
// - Fixed-zero bits read 0 and ignore writes.
// - Writes to read-only nibbles change nothing.
// - Unimplemented addresses read the fixed value 0, writes are ignored.
// - Control nibbles are reached only by the read and write transfers.
// - Addresses 40H to 7FH map to data memory of the selected bank.
// - Addresses below 40H ignore the bank selection.
// - A read copies the nibble into the window, a write copies it out.
// - The register file has 128 nibbles on a seven-bit address.
// ------------------------------------------------------------------
`timescale 1ns/100ps
module crf_control_regs
(
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 regfileReadInstr,
   input  wire logic                 regfileWriteInstr,
   input  wire logic [crf_pkg::ADDR_W-1:0] regfileAddr,
   input  wire logic                 dataBankOne,
   input  wire logic [3:0]           windowIn,
   input  wire logic [3:0]           statusIn [crf_pkg::CTRL_DEPTH],
   output      logic [3:0]           windowOut,
   output      logic                 windowLoad,
   output      logic [3:0]           ctrlOut [crf_pkg::CTRL_DEPTH],
   output      logic                 watchdogRestart,
   output      logic                 watchdogEnable,
   output      logic                 timer0Restart,
   output      logic                 timer1Restart,
   output      logic                 intervalTimerRestart,
   output      logic                 converterStart
);
   import crf_pkg::*;

   typedef enum logic [2:0]
   {
      CRF_IDLE = 3'b001,
      CRF_MEMRD = 3'b010,
      CRF_DONE = 3'b100
   } crf_state_type;

   crf_state_type state_q;
   crf_state_type state_d;
   logic [3:0]    nib_q [CTRL_DEPTH];
   logic [3:0]    nib_d [CTRL_DEPTH];
   logic [3:0]    windowOut_q;
   logic [3:0]    windowOut_d;
   logic          windowLoad_q;
   logic          windowLoad_d;
   logic [5:0]    pulse_q;
   logic [5:0]    pulse_d;
   logic          isMem;
   logic [5:0]    idx;
   logic [3:0]    ctrlRead;

   crf_access_if acc ();

   crf_overlap_mem u_mem
   (
      .clk (clk),
      .acc (acc)
   );

   // ---------------------------------------------------------------
   // Address decode.
   // ---------------------------------------------------------------
   assign isMem = regfileAddr[ADDR_W-1];
   assign idx   = regfileAddr[5:0];
   assign acc.index   = idx;
   assign acc.bankSel = dataBankOne;
   assign acc.wrData  = windowIn;
   assign acc.wrMem   = regfileWriteInstr && isMem;
   assign acc.rdMem   = regfileReadInstr && isMem;
   assign acc.wrCtrl  = regfileWriteInstr && !isMem;

   // Control read ignores the bank; unimplemented reads a fixed value.
   always_comb
   begin
      if (!IMPL_MAP[idx])
      begin
         ctrlRead = UNIMPL_VALUE;
      end
      else if (RDONLY_MAP[idx])
      begin
         ctrlRead = statusIn[idx];
      end
      else
      begin
         ctrlRead = nib_q[idx];
      end
   end

   // ---------------------------------------------------------------
   // Control nibble storage, one entry per address.
   // ---------------------------------------------------------------
   generate
      for (genvar g = 0; g < CTRL_DEPTH; g++)
      begin : gNib
         localparam logic [3:0] MASK =
            (g == int'(OFS_WATCHDOG))  ? STORE_MASK_WD :
            (g == int'(OFS_TIMER0))    ? STORE_MASK_TM :
            (g == int'(OFS_TIMER1))    ? STORE_MASK_TM :
            (g == int'(OFS_INTERVAL))  ? STORE_MASK_TM :
            (g == int'(OFS_CONVERTER)) ? STORE_MASK_CONV :
                                         STORE_MASK_ALL;
         always_comb
         begin
            nib_d[g] = nib_q[g];
            if (acc.wrCtrl && idx == 6'(g) && IMPL_MAP[g] &&
                !RDONLY_MAP[g])
            begin
               nib_d[g] = windowIn & MASK;
            end
         end
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               nib_q[g] <= NIB_RESET;
            end
            else
            begin
               nib_q[g] <= nib_d[g];
            end
         end
         assign ctrlOut[g] = nib_q[g];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Trigger pulses and window transfer sequencing.
   // ---------------------------------------------------------------
   always_comb
   begin
      pulse_d = 6'h00;
      if (acc.wrCtrl)
      begin
         pulse_d[0] = idx == OFS_WATCHDOG[5:0] &&
                      windowIn[BIT_WD_RESTART];
         pulse_d[1] = idx == OFS_WATCHDOG[5:0] &&
                      windowIn[BIT_WD_ENABLE];
         pulse_d[2] = idx == OFS_TIMER0[5:0] &&
                      windowIn[BIT_TM_RESTART];
         pulse_d[3] = idx == OFS_TIMER1[5:0] &&
                      windowIn[BIT_TM_RESTART];
         pulse_d[4] = idx == OFS_INTERVAL[5:0] &&
                      windowIn[BIT_TM_RESTART];
         pulse_d[5] = idx == OFS_CONVERTER[5:0] &&
                      windowIn[BIT_CONV_START];
      end
      state_d      = CRF_IDLE;
      windowOut_d  = windowOut_q;
      windowLoad_d = 1'b0;
      case (state_q)
         CRF_IDLE:
         begin
            if (acc.rdMem)
            begin
               state_d = CRF_MEMRD;
            end
            else if (regfileReadInstr)
            begin
               windowOut_d  = ctrlRead;
               windowLoad_d = 1'b1;
               state_d      = CRF_DONE;
            end
         end
         CRF_MEMRD:
         begin
            windowOut_d  = acc.memRdData;
            windowLoad_d = 1'b1;
            state_d      = CRF_DONE;
         end
         CRF_DONE:
         begin
            state_d = CRF_IDLE;
         end
         default:
         begin
            state_d = CRF_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q      <= CRF_IDLE;
         windowOut_q  <= NIB_RESET;
         windowLoad_q <= 1'b0;
         pulse_q      <= 6'h00;
      end
      else
      begin
         state_q      <= state_d;
         windowOut_q  <= windowOut_d;
         windowLoad_q <= windowLoad_d;
         pulse_q      <= pulse_d;
      end
   end

   assign windowOut            = windowOut_q;
   assign windowLoad           = windowLoad_q;
   assign watchdogRestart      = pulse_q[0];
   assign watchdogEnable       = pulse_q[1];
   assign timer0Restart        = pulse_q[2];
   assign timer1Restart        = pulse_q[3];
   assign intervalTimerRestart = pulse_q[4];
   assign converterStart       = pulse_q[5];
endmodule : crf_control_regs

// [logic/crf_overlap_mem.sv]
// Banked data memory behind register file addresses 40H to 7FH.
`timescale 1ns/100ps
module crf_overlap_mem
(
   input wire logic   clk,
   crf_access_if.mem  acc
);
   import crf_pkg::*;

   logic [3:0] bankZero [MEM_DEPTH];
   logic [3:0] bankOne  [MEM_DEPTH];
   logic [3:0] rdData_q;

   // ---------------------------------------------------------------
   // Storage, selected by the current bank.
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (acc.wrMem && !acc.bankSel)
      begin
         bankZero[acc.index] <= acc.wrData;
      end
      if (acc.wrMem && acc.bankSel)
      begin
         bankOne[acc.index] <= acc.wrData;
      end
      rdData_q <= acc.bankSel ? bankOne[acc.index] : bankZero[acc.index];
   end

   assign acc.memRdData = rdData_q;
endmodule : crf_overlap_mem

// [logic/crf_pkg.sv]
// Package of constants for the control register file.
package crf_pkg;
   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 7;
   localparam int          NIB_W           = 4;
   localparam int          CTRL_DEPTH      = 64;
   localparam int          MEM_DEPTH       = 64;
   localparam logic [6:0]  OFS_WATCHDOG    = 7'h03;
   localparam logic [6:0]  OFS_TIMER0      = 7'h11;
   localparam logic [6:0]  OFS_TIMER1      = 7'h12;
   localparam logic [6:0]  OFS_INTERVAL    = 7'h13;
   localparam logic [6:0]  OFS_CONVERTER   = 7'h20;
   localparam logic [6:0]  OVERLAP_BASE    = 7'h40;
   localparam logic [6:0]  WINDOW_ADDR     = 7'h78;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          BIT_WD_RESTART  = 3;
   localparam int          BIT_WD_ENABLE   = 0;
   localparam int          BIT_TM_RESTART  = 2;
   localparam int          BIT_CONV_START  = 0;
   localparam logic [3:0]  NIB_RESET       = 4'h0;
   localparam logic [3:0]  UNIMPL_VALUE    = 4'h0;
   // Implemented and read-only masks per control address.
   localparam logic [63:0] IMPL_MAP        = 64'h0003_0f0f_000f_ff8e;
   localparam logic [63:0] RDONLY_MAP      = 64'h0002_0000_0000_0004;
   // Bit mask of bits that store a written value in R/W nibbles.
   localparam logic [3:0]  STORE_MASK_WD   = 4'h6;
   localparam logic [3:0]  STORE_MASK_TM   = 4'hb;
   localparam logic [3:0]  STORE_MASK_CONV = 4'he;
   localparam logic [3:0]  STORE_MASK_ALL  = 4'hf;
endpackage : crf_pkg

// [verification/control_register_file_tb.sv]
// Self-checking bench for the control register file.
`timescale 1ns/100ps
module control_register_file_tb;
   import crf_pkg::*;
   // ------------------------------------------------------------
   // Stimulus, scoreboard and checks
   // ------------------------------------------------------------
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       rdInstr = 1'b0;
   logic       wrInstr = 1'b0;
   logic [6:0] addr = 7'h00;
   logic       bankOne = 1'b0;
   logic       coreWrite = 1'b0;
   logic [3:0] coreData = 4'h0;
   logic [3:0] windowIn;
   logic [3:0] windowOut;
   logic       windowLoad;
   logic [3:0] statusIn [64];
   logic [3:0] ctl [64];
   logic [3:0] ctrlOut [64];
   logic [3:0] mem [2][64];
   logic [3:0] expQ [$];
   int         errors = 0;
   int         checks_done = 0;
   int         seed = 39;
   always #5 clk = ~clk;
   crf_control_regs dut_u (.clk(clk), .rst_b(rst_b),
      .regfileReadInstr(rdInstr), .regfileWriteInstr(wrInstr),
      .regfileAddr(addr), .dataBankOne(bankOne), .windowIn(windowIn),
      .statusIn(statusIn), .windowOut(windowOut), .windowLoad(windowLoad),
      .ctrlOut(ctrlOut), .watchdogRestart(), .watchdogEnable(),
      .timer0Restart(),
      .timer1Restart(), .intervalTimerRestart(), .converterStart());
   crf_core_model core_u (.clk(clk), .rst_b(rst_b), .windowOut(windowOut),
      .windowLoad(windowLoad), .coreWrite(coreWrite), .coreData(coreData),
      .windowIn(windowIn));
   task check(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   function automatic logic [3:0] mask(input logic [6:0] a);
      case (a)
         OFS_WATCHDOG: return STORE_MASK_WD;
         OFS_TIMER0, OFS_TIMER1, OFS_INTERVAL: return STORE_MASK_TM;
         OFS_CONVERTER: return STORE_MASK_CONV;
         default: return STORE_MASK_ALL;
      endcase
   endfunction : mask
   task op(input logic rd, input logic [6:0] a, input logic [3:0] d);
      logic [5:0] i;
      i = a[5:0];
      @(negedge clk);
      coreWrite = 1'b1;
      coreData = d;
      @(negedge clk);
      coreWrite = 1'b0;
      rdInstr = rd;
      wrInstr = !rd;
      addr = a;
      if (rd)
         expQ.push_back(a[6] ? mem[bankOne][i] : !IMPL_MAP[i] ? UNIMPL_VALUE
                        : RDONLY_MAP[i] ? statusIn[i] : ctl[i]);
      else if (a[6])
         mem[bankOne][i] = d;
      else if (IMPL_MAP[i] && !RDONLY_MAP[i])
         ctl[i] = d & mask(a);
      @(negedge clk);
      rdInstr = 1'b0;
      wrInstr = 1'b0;
      if (!rd && !a[6])
         check(ctrlOut[i], ctl[i]);
      repeat (2) @(negedge clk);
   endtask : op
   always @(negedge clk)
      if (windowLoad === 1'b1)
         check(windowOut, expQ.pop_front());
   initial
   begin
      for (int i = 0; i < 64; i++)
      begin
         statusIn[i] = 4'($random(seed));
         ctl[i] = NIB_RESET;
      end
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      for (int b = 0; b < 3; b++)
      begin
         bankOne = (b == 1);
         for (int a = b * 64; a < 128; a++)
            op(1'b0, a[6:0], 4'($random(seed)));
         for (int a = 0; a < 128; a++)
            op(1'b1, a[6:0], 4'($random(seed)));
         $display("pass %0d done", b);
      end
      repeat (5) @(negedge clk);
      check(4'(expQ.size()), 4'h0);
      results();
   end
   initial
   begin
      #100000;
      errors++;
      results();
   end
endmodule : control_register_file_tb

// [verification/crf_checker.sv]
// Port assertions for the control register file.
`timescale 1ns/100ps
module crf_checker
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       regfileReadInstr,
   input wire logic       regfileWriteInstr,
   input wire logic [6:0] regfileAddr,
   input wire logic [3:0] windowIn,
   input wire logic [3:0] windowOut,
   input wire logic       windowLoad,
   input wire logic       watchdogRestart,
   input wire logic       watchdogEnable,
   input wire logic       timer0Restart,
   input wire logic       timer1Restart,
   input wire logic       intervalTimerRestart,
   input wire logic       converterStart
);
   // ------------------------------------------------------------
   // Transfer and pulse checks
   // ------------------------------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic       wr;
   logic       rd;
   logic [6:0] ad;
   logic       anyPulse;
   assign wr = regfileWriteInstr;
   assign rd = regfileReadInstr;
   assign ad = regfileAddr;
   assign anyPulse = watchdogRestart | watchdogEnable | timer0Restart
                     | timer1Restart | intervalTimerRestart | converterStart;
   property p_wdRes;
      wr && ad == 7'h03 |=> watchdogRestart == $past(windowIn[3]);
   endproperty
   a_wdRes: assert property (p_wdRes)
      else $error("watchdog restart pulse wrong");
   property p_wdEn; wr && ad == 7'h03 |=> watchdogEnable == $past(windowIn[0]);
   endproperty
   a_wdEn: assert property (p_wdEn)
      else $error("watchdog enable pulse wrong");
   property p_tm0; wr && ad == 7'h11 |=> timer0Restart == $past(windowIn[2]);
   endproperty
   a_tm0: assert property (p_tm0)
      else $error("timer0 restart pulse wrong");
   property p_tm1; wr && ad == 7'h12 |=> timer1Restart == $past(windowIn[2]);
   endproperty
   a_tm1: assert property (p_tm1)
      else $error("timer1 restart pulse wrong");
   property p_intv;
      wr && ad == 7'h13 |=> intervalTimerRestart == $past(windowIn[2]);
   endproperty
   a_intv: assert property (p_intv)
      else $error("interval timer restart pulse wrong");
   property p_conv; wr && ad == 7'h20 |=> converterStart == $past(windowIn[0]);
   endproperty
   a_conv: assert property (p_conv)
      else $error("converter start pulse wrong");
   property p_noPulse; !wr |=> !anyPulse;
   endproperty
   a_noPulse: assert property (p_noPulse)
      else $error("trigger pulse without a write");
   property p_ctlRd; rd && !ad[6] |=> windowLoad
      && ($past(ad) != 7'h03 || (windowOut & 4'h9) == 4'h0);
   endproperty
   a_ctlRd: assert property (p_ctlRd)
      else $error("control read answer wrong");
   property p_memRd; rd && ad[6] |=> !windowLoad ##1 windowLoad;
   endproperty
   a_memRd: assert property (p_memRd)
      else $error("memory read timing wrong");
endmodule : crf_checker

bind crf_control_regs crf_checker chk_u
(
   .clk(clk), .rst_b(rst_b), .regfileReadInstr(regfileReadInstr),
   .regfileWriteInstr(regfileWriteInstr), .regfileAddr(regfileAddr),
   .windowIn(windowIn), .windowOut(windowOut), .windowLoad(windowLoad),
   .watchdogRestart(watchdogRestart), .watchdogEnable(watchdogEnable),
   .timer0Restart(timer0Restart), .converterStart(converterStart),
   .timer1Restart(timer1Restart),
   .intervalTimerRestart(intervalTimerRestart)
);

// [verification/crf_core_model.sv]
// Window register of the processor core feeding the transfer pins.
`timescale 1ns/100ps
module crf_core_model
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] windowOut,
   input  wire logic       windowLoad,
   input  wire logic       coreWrite,
   input  wire logic [3:0] coreData,
   output      logic [3:0] windowIn
);
   // ------------------------------------------------------------
   // Window register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         windowIn <= 4'h0;
      else if (windowLoad)
         windowIn <= windowOut;
      else if (coreWrite)
         windowIn <= coreData;
   end
endmodule : crf_core_model
